// ### rtl/vbi_regs_map.vh
// Purpose: Offsets, field positions, reset values and counts of the
//          vertical-blanking host control registers.
// Assumes: Byte-wide registers at 8-bit sub-addresses.
// Notes:   Definitions only.
`ifndef VBI_REGS_MAP_VH
`define VBI_REGS_MAP_VH

// ----------------------------------------------------------------
// Register sub-addresses
// ----------------------------------------------------------------
`define AUX_ENABLE_ADDR 8'h06
`define ANC_CAPTURE_ADDR 8'h07
`define WRITE_STATUS_ADDR 8'h0e
`define RESET_POWER_ADDR 8'h0f
`define DATA_FIRST_ADDR 8'h10
`define DATA_LAST_ADDR 8'h17

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CC_EN_HI 7
`define CC_EN_LO 6
`define WSS_EN_HI 5
`define WSS_EN_LO 4
`define ANC_CC21_BIT 7
`define ANC_CC284_BIT 6
`define ANC_WSS20_BIT 5
`define ANC_WSS283_BIT 4
`define STATUS_CC21_BIT 4
`define STATUS_CC284_BIT 3
`define STATUS_WSS20_BIT 2
`define STATUS_WSS283_BIT 1
`define SOFT_RESET_BIT 7
`define PD_GENERAL_BIT 6
`define PD_COMPOSITE_BIT 5
`define PD_LUMA_BIT 3
`define PD_CHROMA_BIT 2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define EN_FIELD_RESET 2'b00
`define ANC_NIBBLE_RESET 4'h0
`define CAPTION_RESET 8'h80
`define WIDESCREEN_RESET 8'h00
`define WIDESCREEN_HIGH_MASK 8'h3f
`define CAPTION_BITS 5'd16
`define WIDESCREEN_BITS 5'd14
`define SOFT_RESET_CYCLES 4'h4
`define CYCLES_PER_BIT 8'h08

`endif

// ### rtl/write_status_flag.v
// Purpose: One write-status flag of a VBI data register set.
// Assumes: load and sent are one-cycle pulses.
// Notes:   Reads 1 when the set may be rewritten.
`timescale 1ns/1ps
module write_status_flag (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Events
   input wire init,
   input wire load,
   input wire sent,
   // Flag
   output reg ready
);

   // New data outranks a completed transmission in the same cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ready <= 1'b1;
      end else if (init) begin
         ready <= 1'b1;
      end else if (load) begin
         ready <= 1'b0;
      end else if (sent) begin
         ready <= 1'b1;
      end
   end

endmodule // write_status_flag

// ### rtl/vbi_bit_serializer.v
// Purpose: Shifts a VBI data word out least significant bit first.
// Assumes: start is a one-cycle pulse, ignored while busy.
// Notes:   Each bit holds for cycles_per_bit clocks.
`timescale 1ns/1ps
module vbi_bit_serializer #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Control
   input wire abort,
   input wire start,
   input wire [WIDTH-1:0] word,
   input wire [4:0] nbits,
   input wire [7:0] cycles_per_bit,
   // Serial output
   output reg bit_out,
   output reg busy,
   output reg done
);

   reg [WIDTH-1:0] shift;
   reg [4:0] left;
   reg [7:0] tick;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift <= {WIDTH{1'b0}};
         left <= 5'd0;
         tick <= 8'h00;
         bit_out <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
            bit_out <= 1'b0;
            left <= 5'd0;
         end else if (!busy) begin
            if (start && nbits != 5'd0) begin
               busy <= 1'b1;
               bit_out <= word[0];
               shift <= word >> 1;
               left <= nbits - 5'd1;
               tick <= cycles_per_bit - 8'h01;
            end
         end else if (tick != 8'h00) begin
            tick <= tick - 8'h01;
         end else if (left == 5'd0) begin
            busy <= 1'b0;
            bit_out <= 1'b0;
            done <= 1'b1;
         end else begin
            bit_out <= shift[0];
            shift <= shift >> 1;
            left <= left - 5'd1;
            tick <= cycles_per_bit - 8'h01;
         end
      end
   end

endmodule // vbi_bit_serializer

// ### rtl/vbi_host_control_regs.v
// Purpose: Host control and status registers of the VBI data path:
//          ancillary capture enables, write status, software reset,
//          power down, caption and widescreen data with serial output.
// Assumes: Register port is the decoded side of the serial control
//          interface; line strobes come from the video timing logic.
// Notes:   Function
// Function
// RL1: Bit 7 lets ancillary data load line 21
// RL2: Bit 6 lets ancillary data load line 284
// RL3: Bit 5 lets ancillary data load line 20
// RL4: Bit 4 lets ancillary data load line 283
// RL5: Enables need BT.656 mode; all reset zero
// RL6: Status bit 4 low while line 21 unsent
// RL7: Status bit 3 low while line 284 unsent
// RL8: Status bit 2 low while line 20 unsent
// RL9: Status bit 1 low while line 283 unsent
// RL10: Host rewrites a set only when flag reads 1
// RL11: Soft reset bit self-clears after the sequence
// RL12: Bit 6 powers down all DACs, digital
// RL13: Bit 5 powers down composite DAC only
// RL14: Bit 3 powers down luminance DAC only
// RL15: Bit 2 powers down chrominance DAC; reset zero
// RL16: Caption pair shifts out 16 bits, LSB first
// RL17: Caption enable field selects odd/even/both lines
// RL18: Widescreen enable field selects odd/even/both lines
// RL19: Flag drops on load, rises after transmission
// RL20: Soft reset restores all registers' reset values
`timescale 1ns/1ps
`include "vbi_regs_map.vh"
module vbi_host_control_regs #(
   parameter SETS = 4
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Register port from the serial control interface
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Ancillary data from the BT.656 input
   input wire bt656_mode,
   input wire anc_valid,
   input wire [1:0] anc_set,
   input wire [15:0] anc_data,
   // Video timing: start of a VBI data line of the given set
   input wire line_start,
   input wire [1:0] line_set,
   // Serial VBI data toward the luma path
   output wire vbi_bit,
   output wire vbi_active,
   // Power and reset controls
   output wire power_down_digital,
   output wire dac_off_composite,
   output wire dac_off_luma,
   output wire dac_off_chroma,
   output wire soft_reset_busy
);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   reg [1:0] cc_en;
   reg [1:0] wss_en;
   reg [3:0] anc_en;
   reg pd_general;
   reg pd_composite;
   reg pd_luma;
   reg pd_chroma;
   reg [3:0] srst_cnt;
   reg [7:0] data_mem [0:7];
   reg [1:0] tx_set;
   reg [SETS-1:0] host_load;
   reg [SETS-1:0] anc_load;
   reg [SETS-1:0] line_en;
   reg [15:0] tx_word;
   reg [4:0] tx_bits;
   wire soft_init;
   wire [SETS-1:0] ready;
   wire [SETS-1:0] sent;
   wire tx_start;
   wire tx_done;
   wire tx_busy;
   wire [7:0] status;
   wire [3:0] didx;
   integer i;

   assign soft_init = (srst_cnt != 4'h0);
   assign soft_reset_busy = soft_init;

   // Set order: 0 line 21, 1 line 284, 2 line 20, 3 line 283
   always @* begin
      host_load = {SETS{1'b0}};
      anc_load = {SETS{1'b0}};
      line_en = {wss_en[1], wss_en[0], cc_en[1], cc_en[0]}; // RL17 RL18
      for (i = 0; i < SETS; i = i + 1) begin
         if (reg_wr && !soft_init &&
               reg_addr[7:1] == (`DATA_FIRST_ADDR >> 1) + i) begin
            host_load[i] = 1'b1; // RL19
         end
         // Capture needs BT.656 mode and the per-set enable
         if (anc_valid && bt656_mode && anc_en[3-i] && !soft_init &&
               anc_set == i) begin
            anc_load[i] = 1'b1; // RL1 RL2 RL3 RL4 RL5
         end
      end
   end

   // ----------------------------------------------------------------
   // Register writes and the software reset sequence
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cc_en <= `EN_FIELD_RESET;
         wss_en <= `EN_FIELD_RESET;
         anc_en <= `ANC_NIBBLE_RESET;
         pd_general <= 1'b0;
         pd_composite <= 1'b0;
         pd_luma <= 1'b0;
         pd_chroma <= 1'b0;
         srst_cnt <= 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            data_mem[i] <= (i < 4) ? `CAPTION_RESET : `WIDESCREEN_RESET;
         end
      end else if (soft_init) begin
         // Hold everything at reset values until the count runs out
         cc_en <= `EN_FIELD_RESET; // RL20
         wss_en <= `EN_FIELD_RESET;
         anc_en <= `ANC_NIBBLE_RESET;
         pd_general <= 1'b0;
         pd_composite <= 1'b0;
         pd_luma <= 1'b0;
         pd_chroma <= 1'b0;
         srst_cnt <= srst_cnt - 4'h1; // RL11
         for (i = 0; i < 8; i = i + 1) begin
            data_mem[i] <= (i < 4) ? `CAPTION_RESET : `WIDESCREEN_RESET;
         end
      end else begin
         if (reg_wr) begin
            if (reg_addr == `AUX_ENABLE_ADDR) begin
               cc_en <= reg_wdata[`CC_EN_HI:`CC_EN_LO]; // RL17
               wss_en <= reg_wdata[`WSS_EN_HI:`WSS_EN_LO]; // RL18
            end else if (reg_addr == `ANC_CAPTURE_ADDR) begin
               anc_en <= reg_wdata[`ANC_CC21_BIT:`ANC_WSS283_BIT]; // RL5
            end else if (reg_addr == `RESET_POWER_ADDR) begin
               pd_general <= reg_wdata[`PD_GENERAL_BIT]; // RL12
               pd_composite <= reg_wdata[`PD_COMPOSITE_BIT]; // RL13
               pd_luma <= reg_wdata[`PD_LUMA_BIT]; // RL14
               pd_chroma <= reg_wdata[`PD_CHROMA_BIT]; // RL15
               if (reg_wdata[`SOFT_RESET_BIT]) begin
                  srst_cnt <= `SOFT_RESET_CYCLES; // RL11
               end
            end else if (reg_addr >= `DATA_FIRST_ADDR &&
                  reg_addr <= `DATA_LAST_ADDR) begin
               data_mem[reg_addr[2:0]] <= reg_wdata;
            end
         end
         // Ancillary capture loads a whole byte pair
         for (i = 0; i < SETS; i = i + 1) begin
            if (anc_load[i]) begin
               data_mem[2*i] <= anc_data[7:0]; // RL1 RL2 RL3 RL4
               data_mem[2*i+1] <= anc_data[15:8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Write-status flags
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < SETS; g = g + 1) begin : flag
         assign sent[g] = tx_done && (tx_set == g);
         write_status_flag u_flag (
            .clk(clk),
            .rstn(rstn),
            .init(soft_init),
            .load(host_load[g] | anc_load[g]),
            .sent(sent[g]),
            .ready(ready[g])
         ); // RL6 RL7 RL8 RL9 RL19
      end
   endgenerate

   assign status = {3'b000, ready[0], ready[1], ready[2], ready[3],
      1'b0}; // RL6 RL7 RL8 RL9

   // ----------------------------------------------------------------
   // Line transmission
   // ----------------------------------------------------------------
   assign didx = {1'b0, line_set, 1'b0};
   assign tx_start = line_start && line_en[line_set] && !tx_busy &&
      !pd_general && !soft_init;

   // Caption sends 16 bits, widescreen the 14 valid bits
   always @* begin
      if (line_set[1]) begin
         tx_word = {data_mem[didx[2:0] + 3'd1] & `WIDESCREEN_HIGH_MASK,
            data_mem[didx[2:0]]};
         tx_bits = `WIDESCREEN_BITS;
      end else begin
         tx_word = {data_mem[didx[2:0] + 3'd1], data_mem[didx[2:0]]};
         tx_bits = `CAPTION_BITS; // RL16
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_set <= 2'b00;
      end else if (tx_start) begin
         tx_set <= line_set;
      end
   end

   vbi_bit_serializer #(
      .WIDTH(16)
   ) u_serializer (
      .clk(clk),
      .rstn(rstn),
      .abort(soft_init | pd_general),
      .start(tx_start),
      .word(tx_word),
      .nbits(tx_bits),
      .cycles_per_bit(`CYCLES_PER_BIT),
      .bit_out(vbi_bit),
      .busy(tx_busy),
      .done(tx_done)
   ); // RL16

   assign vbi_active = tx_busy;

   // ----------------------------------------------------------------
   // Power-down outputs
   // ----------------------------------------------------------------
   assign power_down_digital = pd_general; // RL12
   assign dac_off_composite = pd_general | pd_composite; // RL13
   assign dac_off_luma = pd_general | pd_luma; // RL14
   assign dac_off_chroma = pd_general | pd_chroma; // RL15

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `AUX_ENABLE_ADDR) begin
            reg_rdata <= {cc_en, wss_en, 4'h0};
         end else if (reg_addr == `ANC_CAPTURE_ADDR) begin
            reg_rdata <= {anc_en, 4'h0};
         end else if (reg_addr == `WRITE_STATUS_ADDR) begin
            reg_rdata <= status;
         end else if (reg_addr == `RESET_POWER_ADDR) begin
            reg_rdata <= {soft_init, pd_general, pd_composite, 1'b0,
               pd_luma, pd_chroma, 2'b00}; // RL11
         end else if (reg_addr >= `DATA_FIRST_ADDR &&
               reg_addr <= `DATA_LAST_ADDR) begin
            if (reg_addr[2] && reg_addr[0]) begin
               reg_rdata <= data_mem[reg_addr[2:0]] & `WIDESCREEN_HIGH_MASK;
            end else begin
               reg_rdata <= data_mem[reg_addr[2:0]];
            end
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule // vbi_host_control_regs

// ### dv/vbi_host_control_regs_checker.sv
// Purpose: Port checks of the VBI host control registers.
// Assumes: One clock domain, rstn asynchronous and active low.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module vbi_host_control_regs_checker (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Line timing
   input wire line_start,
   input wire [1:0] line_set,
   // Outputs
   input wire vbi_bit,
   input wire vbi_active,
   input wire power_down_digital,
   input wire dac_off_composite,
   input wire dac_off_luma,
   input wire dac_off_chroma,
   input wire soft_reset_busy
);
   // ------------------------------------------------------------
   // Helpers: shifting time and a copy of the line enables
   // ------------------------------------------------------------
   logic [7:0] run;
   logic [7:0] aux;
   wire [2:0] ei = (line_set[1] ? 3'h4 : 3'h6) + {2'h0, line_set[0]};
   wire en = aux[ei];
   wire [3:0] pw = {power_down_digital, dac_off_composite, dac_off_luma,
      dac_off_chroma};
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run <= 8'h00;
         aux <= 8'h00;
      end else begin
         run <= vbi_active ? run + 8'h01 : 8'h00;
         if (soft_reset_busy)
            aux <= 8'h00;
         else if (reg_wr && reg_addr == 8'h06)
            aux <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_pd_all;
      power_down_digital |-> pw == 4'hf;
   endproperty
   a_pd_all: assert property (p_pd_all)
      else $error("dac outputs on in general power down");
   property p_pd_stop;
      power_down_digital [*3] |-> !vbi_active;
   endproperty
   a_pd_stop: assert property (p_pd_stop)
      else $error("line sent during power down");
   property p_sr_len;
      $rose(soft_reset_busy) |-> soft_reset_busy [*4] ##1 !soft_reset_busy;
   endproperty
   a_sr_len: assert property (p_sr_len)
      else $error("soft reset length wrong");
   property p_sr_go;
      reg_wr && reg_addr == 8'h0f && reg_wdata[7] && !soft_reset_busy
         |=> soft_reset_busy;
   endproperty
   a_sr_go: assert property (p_sr_go)
      else $error("soft reset did not start");
   property p_sr_pd;
      soft_reset_busy [*2] |-> pw == 4'h0;
   endproperty
   a_sr_pd: assert property (p_sr_pd)
      else $error("power controls kept through soft reset");
   property p_len;
      $fell(vbi_active) && !power_down_digital && !soft_reset_busy
         |-> run == 8'h80 || run == 8'h70;
   endproperty
   a_len: assert property (p_len)
      else $error("line length wrong");
   property p_bit;
      vbi_active && $past(vbi_active) && $changed(vbi_bit)
         |-> run[2:0] == 3'h0;
   endproperty
   a_bit: assert property (p_bit)
      else $error("serial bit changed inside its period");
   property p_line_on;
      line_start && en && !vbi_active && !power_down_digital &&
         !soft_reset_busy |=> vbi_active;
   endproperty
   a_line_on: assert property (p_line_on)
      else $error("enabled line not sent");
   property p_line_off;
      line_start && !en && !vbi_active |=> !vbi_active;
   endproperty
   a_line_off: assert property (p_line_off)
      else $error("disabled line sent");
   property p_nib;
      reg_rd && reg_addr == 8'h07 |=> reg_rdata[3:0] == 4'h0;
   endproperty
   a_nib: assert property (p_nib)
      else $error("reserved capture bits read nonzero");
   c_line: cover property ($fell(vbi_active));
   c_sr: cover property ($rose(soft_reset_busy));
   c_pd: cover property ($rose(power_down_digital));
endmodule // vbi_host_control_regs_checker

bind vbi_host_control_regs vbi_host_control_regs_checker i_checker (
   .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .line_start(line_start), .line_set(line_set), .vbi_bit(vbi_bit),
   .vbi_active(vbi_active), .power_down_digital(power_down_digital),
   .dac_off_composite(dac_off_composite), .dac_off_luma(dac_off_luma),
   .dac_off_chroma(dac_off_chroma), .soft_reset_busy(soft_reset_busy));

// ### dv/host_model.sv
// Purpose: Host side of the register port.
// Assumes: Strobes are taken at the rising edge.
// Notes: Released lines carry inverted values.
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 v = reg_rdata;
   endtask
   // Rewrites a byte pair only once its set has been sent
   task automatic put(input int s, input logic [15:0] w, output bit ok);
      logic [7:0] st;
      ok = 1'b0;
      for (int i = 0; i < 300 && !ok; i++) begin
         rd(8'h0e, st);
         ok = st[4 - s] === 1'b1;
      end
      if (ok) begin
         wr(8'h10 + 8'(2 * s), w[7:0]);
         wr(8'h11 + 8'(2 * s), w[15:8]);
      end
   endtask
endmodule // host_model

// ### dv/vbi_host_control_regs_tb_top.sv
// Purpose: Self-checking bench of the VBI host control registers.
// Assumes: 125 MHz clock, rstn active low.
// Notes: Reset values first, then rows, soft reset, capture and line tests.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module vbi_host_control_regs_tb_top;
   logic clk, rstn, reg_wr, reg_rd, bt656_mode, anc_valid, line_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, st;
   logic [1:0] anc_set, line_set;
   logic [15:0] anc_data, w;
   logic vbi_bit, vbi_active, pdd, dco, dlu, dch, srb;
   int mismatches, comparisons;
   bit ok;
   typedef struct packed {logic [7:0] a, wd, rx; logic [3:0] px;} row_t;
   // Address, write data, read back, power outputs
   row_t rows [9] = '{28'h07fff00, 28'h0f20204, 28'h0f08082, 28'h0f04041,
      28'h0f4040f, 28'h0f13000, 28'h0eff1e0, 28'h15ff3f0, 28'h06f0f00};
   vbi_host_control_regs i_vbi_host_control_regs (.clk(clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bt656_mode(bt656_mode),
      .anc_valid(anc_valid), .anc_set(anc_set), .anc_data(anc_data),
      .line_start(line_start), .line_set(line_set), .vbi_bit(vbi_bit),
      .vbi_active(vbi_active), .power_down_digital(pdd),
      .dac_off_composite(dco), .dac_off_luma(dlu), .dac_off_chroma(dch),
      .soft_reset_busy(srb));
   host_model i_host_model (.clk(clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_until(input bit sel, input logic v);
      int n;
      #1;
      for (n = 0; n < 400; n++) begin
         if ((sel ? vbi_active : srb) === v)
            break;
         @(posedge clk);
         #1;
      end
      if (n == 400) begin
         mismatches++;
         wrap_up();
      end
   endtask
   task automatic check_resets();
      logic [15:0] t [8] = '{16'h0600, 16'h0700, 16'h0e1e, 16'h0f00,
         16'h1080, 16'h1380, 16'h1500, 16'h2000};
      logic [7:0] v;
      foreach (t[i]) begin
         i_host_model.rd(t[i][15:8], v);
         `CHK("reset value", t[i][7:0], v)
      end
      `CHK("power at reset", 4'h0, {pdd, dco, dlu, dch})
      $display("reset test done");
   endtask
   task automatic line_pulse(input int s);
      @(posedge clk);
      line_start <= 1'b1;
      line_set <= 2'(s);
      @(posedge clk);
      line_start <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {rstn, bt656_mode, anc_valid, line_start} = 4'h0;
      {anc_set, line_set, anc_data} = 20'h00000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      check_resets();
      foreach (rows[i]) begin
         i_host_model.wr(rows[i].a, rows[i].wd);
         i_host_model.rd(rows[i].a, d);
         `CHK("readback", rows[i].rx, d)
         `CHK("power", rows[i].px, {pdd, dco, dlu, dch})
      end
      $display("row tests done");
      i_host_model.wr(8'h0f, 8'h80);
      i_host_model.rd(8'h0f, d);
      `CHK("soft reset bit", 1'b1, d[7])
      wait_until(0, 1'b0);
      i_host_model.rd(8'h0f, d);
      `CHK("soft reset cleared", 8'h00, d)
      check_resets();
      st = 8'h1e;
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 3; k++) begin
            i_host_model.wr(8'h07, k == 0 ? 8'h00 : 8'h80 >> s);
            @(posedge clk);
            bt656_mode <= k != 1;
            anc_set <= 2'(s);
            anc_data <= {8'h3c, 8'h5a ^ 8'(s)};
            anc_valid <= 1'b1;
            @(posedge clk);
            anc_valid <= 1'b0;
            if (k == 2)
               st[4 - s] = 1'b0;
            i_host_model.rd(8'h0e, d);
            `CHK("write status", st, d)
         end
         i_host_model.rd(8'h10 + 8'(2 * s), d);
         `CHK("captured byte", 8'h5a ^ 8'(s), d)
      end
      $display("capture test done");
      for (int m = 0; m < 4; m++) begin
         i_host_model.wr(8'h06, 8'(m * 8'h50));
         for (int s = 0; s < 4; s++) begin
            line_pulse(s);
            @(posedge clk);
            #1;
            `CHK("line sent", m[s % 2], vbi_active)
            wait_until(1, 1'b0);
            @(posedge clk);
         end
      end
      i_host_model.rd(8'h0e, d);
      `CHK("all sent", 8'h1e, d)
      $display("enable test done");
      i_host_model.put(0, 16'h9241, ok);
      `CHK("host may write", 1'b1, ok)
      i_host_model.rd(8'h0e, d);
      `CHK("pending status", 8'h0e, d)
      line_pulse(0);
      wait_until(1, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      for (int b = 0; b < 16; b++) begin
         w[b] = vbi_bit;
         repeat (8) @(posedge clk);
      end
      `CHK("serial word", 16'h9241, w)
      wait_until(1, 1'b0);
      repeat (2) @(posedge clk);
      i_host_model.rd(8'h0e, d);
      `CHK("sent status", 8'h1e, d)
      $display("serial test done");
      line_pulse(2);
      repeat (20) @(posedge clk);
      i_host_model.wr(8'h0f, 8'h40);
      repeat (3) @(posedge clk);
      #1;
      `CHK("abort on power down", 1'b0, vbi_active)
      line_pulse(0);
      repeat (2) @(posedge clk);
      #1;
      `CHK("blocked in power down", 1'b0, vbi_active)
      $display("power down test done");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      check_resets();
      wrap_up();
   end
endmodule // vbi_host_control_regs_tb_top
